// file: rtl/taev_event_logic.sv
// Alarm window, critical trip and event pin logic of a temperature sensor.
// Assumes a protocol engine giving a pointer, a write strobe and data, and a
// converter that pulses a strobe with each new 16-bit result.
// How it works
// RULE1: Event status reads one exactly while the pin is driven active.
// RULE2: Event status bit ignores writes.
// RULE3: Writing one to clear releases a latched interrupt event.
// RULE4: Output enable defaults off, gates the pin, frozen under either lock.
// RULE5: Critical-only clear: window and critical conditions both raise events.
// RULE6: Critical-only set: only the critical condition raises events.
// RULE7: Window lock blocks writes to the critical-only bit.
// RULE8: Polarity bit: zero active low, one active high; frozen by locks.
// RULE9: Mode bit: zero comparator, one interrupt; frozen by locks.
// RULE10: Above-window sets above upper, clears at upper minus hysteresis.
// RULE11: Below-window sets at lower minus hysteresis, clears at lower.
// RULE12: Temperatures and limits are two's complement, 0.0625 degC per LSB.
// RULE13: Temperature resolution is 0.125 degC; bit 0 reads zero.
// RULE14: Top three temperature bits show trip status, not pin state.
// RULE15: Upper limit keeps sign bit 12 and value 11:2; others zero.
// RULE16: Lower limit uses the same layout as the upper limit.
// RULE17: Limit reserved bits read zero and ignore writes.
// RULE18: Comparisons always use the limits currently programmed.
// RULE19: Software should disable events while changing limits in operation.
// RULE20: Clear has no effect in comparator mode and reads zero.
// RULE21: Lock bits set with one write and hold until reset.
// RULE22: Above-critical reads one when temperature is at or above critical.
// RULE23: In shutdown no events are generated.
// RULE24: Comparator mode follows the condition; interrupt mode latches it.
// RULE25: Trip flags and event are evaluated on each new conversion.
`timescale 1ns/1ps
module taev_event_logic
  import taev_pkg::*;
(
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [3:0] reg_ptr, // Register pointer from protocol engine
  input wire logic reg_wr, // One-cycle write strobe
  input wire logic [15:0] reg_wdata, // Write data
  output logic [15:0] reg_rdata, // Read data for the pointed register
  input wire logic conv_valid, // One-cycle strobe, new conversion result
  input wire logic [15:0] conv_temp, // Raw conversion result
  output logic shutdown, // Shutdown request to the converter
  output logic event_pin_o, // Event pin level
  output logic event_pin_oe // Event pin output enable
);

  // Configuration state
  logic mode_int;
  logic polarity;
  logic crit_only;
  logic out_enable;
  logic window_lock;
  logic critical_lock;
  logic [1:0] hyst_sel;
  // Limits and measurement
  logic [15:0] alarm_window_high_limit;
  logic [15:0] alarm_window_low_limit;
  logic [15:0] critical_limit_value;
  logic [15:0] temp_value;
  // Trip flags and event state
  logic above_critical_flag;
  logic above_window_flag;
  logic below_window_flag;
  logic prev_cond;
  logic int_latched;
  logic trip_cond;
  logic event_active;
  logic event_asserted_flag;
  logic any_lock;
  logic wr_cfg;
  logic clear_req;
  logic [14:0] hyst;
  logic [14:0] t_s;
  logic [14:0] hi_s;
  logic [14:0] lo_s;
  logic [14:0] cr_s;
  logic next_above;
  logic next_below;
  logic next_crit;
  logic next_cond;

  // Sign-extend a 13-bit field so subtraction cannot wrap
  function automatic logic [14:0] taev_sext(input logic [15:0] w);
    taev_sext = {{2{w[TAEV_SIGN_BIT]}}, w[TAEV_SIGN_BIT:0]};
  endfunction

  // Signed compare a >= b on sign-extended words
  function automatic logic taev_ge(input logic [14:0] a,
                                   input logic [14:0] b);
    taev_ge = ($signed(a) >= $signed(b));
  endfunction

  assign any_lock = window_lock | critical_lock;
  assign wr_cfg = reg_wr && (reg_ptr == TAEV_PTR_CONFIG);
  assign clear_req = wr_cfg && reg_wdata[TAEV_CFG_CLR] && mode_int; // RULE3 RULE20

  // Configuration bits; all but shutdown are frozen by their own lock set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_int <= 1'b0;
      polarity <= 1'b0;
      crit_only <= 1'b0;
      out_enable <= 1'b0;
      hyst_sel <= 2'h0;
      shutdown <= 1'b0;
    end else if (ce && wr_cfg) begin
      shutdown <= reg_wdata[TAEV_CFG_SHDN];
      if (!any_lock) begin
        mode_int <= reg_wdata[TAEV_CFG_MODE]; // RULE9
        polarity <= reg_wdata[TAEV_CFG_POL]; // RULE8
        out_enable <= reg_wdata[TAEV_CFG_OE]; // RULE4
        hyst_sel <= reg_wdata[TAEV_CFG_HYST_HI:TAEV_CFG_HYST_LO];
      end
      if (!window_lock) begin
        crit_only <= reg_wdata[TAEV_CFG_CRONLY]; // RULE7
      end
    end
  end

  // Locks only ever set; a single write suffices, only reset clears them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      window_lock <= 1'b0;
      critical_lock <= 1'b0;
    end else if (ce && wr_cfg) begin
      if (reg_wdata[TAEV_CFG_WLOCK]) begin
        window_lock <= 1'b1; // RULE21
      end
      if (reg_wdata[TAEV_CFG_CLOCK]) begin
        critical_lock <= 1'b1; // RULE21
      end
    end
  end

  // Limit registers; reserved bits are masked on write so they stay zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alarm_window_high_limit <= TAEV_RESET_WORD;
      alarm_window_low_limit <= TAEV_RESET_WORD;
      critical_limit_value <= TAEV_RESET_WORD;
    end else if (ce && reg_wr) begin
      if (reg_ptr == TAEV_PTR_HIGH && !window_lock) begin
        alarm_window_high_limit <= reg_wdata & TAEV_LIMIT_MASK; // RULE15 RULE17
      end
      if (reg_ptr == TAEV_PTR_LOW && !window_lock) begin
        alarm_window_low_limit <= reg_wdata & TAEV_LIMIT_MASK; // RULE16 RULE17
      end
      if (reg_ptr == TAEV_PTR_CRIT && !critical_lock) begin
        critical_limit_value <= reg_wdata & TAEV_LIMIT_MASK;
      end
    end
  end

  // Hysteresis step in temperature LSBs
  always_comb begin
    unique case (hyst_sel)
      TAEV_HSEL_0C0: hyst = TAEV_HYST_0C0;
      TAEV_HSEL_1C5: hyst = TAEV_HYST_1C5;
      TAEV_HSEL_3C0: hyst = TAEV_HYST_3C0;
      default: hyst = TAEV_HYST_6C0;
    endcase
  end

  // Compare the incoming result against the live limits
  assign t_s = taev_sext(conv_temp & TAEV_TEMP_MASK); // RULE12 RULE13
  assign hi_s = taev_sext(alarm_window_high_limit); // RULE18
  assign lo_s = taev_sext(alarm_window_low_limit); // RULE18
  assign cr_s = taev_sext(critical_limit_value); // RULE18

  always_comb begin
    next_crit = taev_ge(t_s, cr_s); // RULE22
    next_above = above_window_flag;
    next_below = below_window_flag;
    // Hysteresis lowers the above-window release point and the below-window trip point
    if (!above_window_flag && !taev_ge(hi_s, t_s)) begin
      next_above = 1'b1; // RULE10
    end else if (above_window_flag && taev_ge(hi_s - hyst, t_s)) begin
      next_above = 1'b0; // RULE10
    end
    if (!below_window_flag && taev_ge(lo_s - hyst, t_s)) begin
      next_below = 1'b1; // RULE11
    end else if (below_window_flag && taev_ge(t_s, lo_s)) begin
      next_below = 1'b0; // RULE11
    end
    if (crit_only) begin
      next_cond = next_crit; // RULE6
    end else begin
      next_cond = next_crit | next_above | next_below; // RULE5
    end
  end

  // Trip flags and measurement update on each accepted conversion
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      temp_value <= TAEV_RESET_WORD;
      above_critical_flag <= 1'b0;
      above_window_flag <= 1'b0;
      below_window_flag <= 1'b0;
    end else if (ce && conv_valid && !shutdown) begin
      temp_value <= conv_temp & TAEV_TEMP_MASK; // RULE13 RULE25
      above_critical_flag <= next_crit; // RULE25
      above_window_flag <= next_above; // RULE25
      below_window_flag <= next_below; // RULE25
    end
  end

  // Condition selection follows the live critical-only bit
  assign trip_cond = crit_only ? above_critical_flag
                   : (above_critical_flag | above_window_flag
                      | below_window_flag); // RULE5 RULE6

  // Interrupt latch: set on a fresh trip, released by clear; set wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_cond <= 1'b0;
      int_latched <= 1'b0;
    end else if (ce) begin
      if (conv_valid && !shutdown) begin
        prev_cond <= next_cond;
      end
      if (conv_valid && !shutdown && next_cond && !prev_cond) begin
        int_latched <= 1'b1; // RULE24
      end else if (clear_req) begin
        int_latched <= 1'b0; // RULE3
      end
    end
  end

  // Pin is active only when enabled and the sensor is running
  assign event_active = out_enable && !shutdown
                        && (mode_int ? int_latched : trip_cond); // RULE4 RULE23 RULE24
  assign event_asserted_flag = event_active; // RULE1
  assign event_pin_o = polarity ? event_active : !event_active; // RULE8
  assign event_pin_oe = out_enable; // RULE4

  // Read mux; status bit is computed, never stored, so writing it has no effect
  always_comb begin
    reg_rdata = TAEV_RESET_WORD;
    unique case (reg_ptr)
      TAEV_PTR_CONFIG: begin
        reg_rdata[TAEV_CFG_MODE] = mode_int;
        reg_rdata[TAEV_CFG_POL] = polarity;
        reg_rdata[TAEV_CFG_CRONLY] = crit_only;
        reg_rdata[TAEV_CFG_OE] = out_enable;
        reg_rdata[TAEV_CFG_STAT] = event_asserted_flag; // RULE1 RULE2
        reg_rdata[TAEV_CFG_WLOCK] = window_lock;
        reg_rdata[TAEV_CFG_CLOCK] = critical_lock;
        reg_rdata[TAEV_CFG_SHDN] = shutdown;
        reg_rdata[TAEV_CFG_HYST_HI:TAEV_CFG_HYST_LO] = hyst_sel;
      end
      TAEV_PTR_HIGH: reg_rdata = alarm_window_high_limit;
      TAEV_PTR_LOW: reg_rdata = alarm_window_low_limit;
      TAEV_PTR_CRIT: reg_rdata = critical_limit_value;
      TAEV_PTR_TEMP: begin
        reg_rdata = temp_value;
        reg_rdata[TAEV_TMP_CRIT] = above_critical_flag; // RULE14
        reg_rdata[TAEV_TMP_ABOVE] = above_window_flag; // RULE14
        reg_rdata[TAEV_TMP_BELOW] = below_window_flag; // RULE14
      end
      default: reg_rdata = TAEV_RESET_WORD;
    endcase
  end

  // Checks on the design's own outputs and state
  a_status_pin_tie: assert property (@(posedge clk_sys) disable iff (reset)
    event_pin_o == (polarity ? event_asserted_flag : !event_asserted_flag))
    else $error("pin level disagrees with event status"); // RULE1

  a_status_write_ignored: assert property (@(posedge clk_sys)
    disable iff (reset)
    ce && wr_cfg && !mode_int && $stable(above_critical_flag)
    && !conv_valid |=> $stable(event_asserted_flag) || !out_enable
    || $changed(out_enable) || $changed(mode_int)
    || $changed(crit_only) || $changed(shutdown))
    else $error("status bit moved on a config write"); // RULE2

  a_clear_releases: assert property (@(posedge clk_sys) disable iff (reset)
    ce && clear_req && !conv_valid |=> !int_latched)
    else $error("clear did not release latched event"); // RULE3

  a_enable_gates: assert property (@(posedge clk_sys) disable iff (reset)
    !out_enable |-> !event_asserted_flag)
    else $error("event active while output disabled"); // RULE4

  a_crit_only_gate: assert property (@(posedge clk_sys) disable iff (reset)
    crit_only && !mode_int && event_asserted_flag |-> above_critical_flag)
    else $error("critical-only event without critical trip"); // RULE6

  a_cronly_frozen: assert property (@(posedge clk_sys) disable iff (reset)
    window_lock |=> $stable(crit_only))
    else $error("critical-only bit changed under window lock"); // RULE7

  a_config_frozen: assert property (@(posedge clk_sys) disable iff (reset)
    any_lock |=> $stable(polarity) && $stable(mode_int)
    && $stable(out_enable))
    else $error("locked configuration bit changed"); // RULE8

  a_lock_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    critical_lock && window_lock |-> ##1 critical_lock ##1 window_lock)
    else $error("lock bit released without reset"); // RULE21

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (alarm_window_high_limit & ~TAEV_LIMIT_MASK) == TAEV_RESET_WORD
    && (alarm_window_low_limit & ~TAEV_LIMIT_MASK) == TAEV_RESET_WORD)
    else $error("limit reserved bits not zero"); // RULE17

  a_clear_reads_zero: assert property (@(posedge clk_sys) disable iff (reset)
    reg_ptr == TAEV_PTR_CONFIG |-> !reg_rdata[TAEV_CFG_CLR])
    else $error("clear bit read back as one"); // RULE20

  a_shutdown_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    shutdown |-> !event_asserted_flag)
    else $error("event raised in shutdown"); // RULE23

  a_comparator_follow: assert property (@(posedge clk_sys)
    disable iff (reset)
    !mode_int && out_enable && !shutdown |-> event_asserted_flag == trip_cond)
    else $error("comparator output not following trip"); // RULE24

  a_conv_crit_update: assert property (@(posedge clk_sys) disable iff (reset)
    ce && conv_valid && !shutdown |=> above_critical_flag == $past(next_crit))
    else $error("critical flag not updated on conversion"); // RULE25

endmodule // taev_event_logic

// file: rtl/taev_pkg.sv
// Package for the thermal alarm and event block: pointers, field layouts,
// reset values and hysteresis steps.
// Assumes a serial protocol engine that delivers register pointer and data.
package taev_pkg;
  // Register pointers as seen by the serial protocol engine
  localparam logic [3:0] TAEV_PTR_CONFIG = 4'h1;
  localparam logic [3:0] TAEV_PTR_HIGH = 4'h2;
  localparam logic [3:0] TAEV_PTR_LOW = 4'h3;
  localparam logic [3:0] TAEV_PTR_CRIT = 4'h4;
  localparam logic [3:0] TAEV_PTR_TEMP = 4'h5;

  // Configuration register bit positions
  localparam int TAEV_CFG_MODE = 0;
  localparam int TAEV_CFG_POL = 1;
  localparam int TAEV_CFG_CRONLY = 2;
  localparam int TAEV_CFG_OE = 3;
  localparam int TAEV_CFG_STAT = 4;
  localparam int TAEV_CFG_CLR = 5;
  localparam int TAEV_CFG_WLOCK = 6;
  localparam int TAEV_CFG_CLOCK = 7;
  localparam int TAEV_CFG_SHDN = 8;
  localparam int TAEV_CFG_HYST_LO = 9;
  localparam int TAEV_CFG_HYST_HI = 10;

  // Temperature register trip and sign bit positions
  localparam int TAEV_TMP_CRIT = 15;
  localparam int TAEV_TMP_ABOVE = 14;
  localparam int TAEV_TMP_BELOW = 13;
  localparam int TAEV_SIGN_BIT = 12;

  // Limit layout: sign in bit 12, value in bits 11:2, the rest reserved
  localparam logic [15:0] TAEV_LIMIT_MASK = 16'h1ffc;
  // Temperature layout: sign in bit 12, value in bits 11:1
  localparam logic [15:0] TAEV_TEMP_MASK = 16'h1ffe;
  localparam logic [15:0] TAEV_RESET_WORD = 16'h0000;

  // Hysteresis steps in units of 0.0625 degC
  localparam logic [14:0] TAEV_HYST_0C0 = 15'h0000;
  localparam logic [14:0] TAEV_HYST_1C5 = 15'h0018;
  localparam logic [14:0] TAEV_HYST_3C0 = 15'h0030;
  localparam logic [14:0] TAEV_HYST_6C0 = 15'h0060;

  localparam logic [1:0] TAEV_HSEL_0C0 = 2'h0;
  localparam logic [1:0] TAEV_HSEL_1C5 = 2'h1;
  localparam logic [1:0] TAEV_HSEL_3C0 = 2'h2;
endpackage

// file: verif/taev_host_model.sv
// Host-side receiver of the sensor's event line.
// Assumes the event line carries a pull-up, as shared event wiring does.
`timescale 1ns/1ps
module taev_host_model (
  input wire logic pin_o, // Level driven by the sensor
  input wire logic pin_oe, // Drive enable from the sensor
  output logic line // Line level as the host sees it
);
  // An undriven line floats to the pull-up, never to the last level
  assign line = pin_oe ? pin_o : 1'b1;
endmodule // taev_host_model

// file: verif/thermal_alarm_event_logic_test.sv
// Self-checking bench for the alarm window, critical trip and event pin.
// Assumes the protocol engine and converter are replaced by bench tasks.
`timescale 1ns/1ps
module thermal_alarm_event_logic_test;
  import taev_pkg::*;
  // Hysteresis step for the programmed selection, in 0.0625 degC units
  function automatic logic signed [13:0] hys(input logic [1:0] s);
    case (s)
      TAEV_HSEL_0C0: return 14'(TAEV_HYST_0C0);
      TAEV_HSEL_1C5: return 14'(TAEV_HYST_1C5);
      TAEV_HSEL_3C0: return 14'(TAEV_HYST_3C0);
      default: return 14'(TAEV_HYST_6C0);
    endcase
  endfunction
  logic clk_sys = 1'b0, reset = 1'b1, ce = 1'b1;
  logic reg_wr = 1'b0, conv_valid = 1'b0;
  logic [3:0] reg_ptr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, conv_temp = 16'h0000;
  logic [15:0] reg_rdata;
  logic shutdown, event_pin_o, event_pin_oe, line;
  logic [15:0] m_up, m_lo, m_cr, m_cfg, m_tmp;
  logic m_ac, m_aw, m_bw;
  int fail_count = 0, checked = 0, cyc = 0;

  taev_event_logic dut_u (.clk_sys(clk_sys), .reset(reset), .ce(ce),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_temp(conv_temp),
    .shutdown(shutdown), .event_pin_o(event_pin_o),
    .event_pin_oe(event_pin_oe));
  taev_host_model host_u (.pin_o(event_pin_o), .pin_oe(event_pin_oe),
    .line(line));

  // Free-running 25 MHz clock
  initial forever #20 clk_sys = ~clk_sys;

  task automatic final_report;
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [3:0] p, input logic [15:0] e, string n);
    @(negedge clk_sys);
    reg_ptr = p;
    #1 chk(n, e, reg_rdata);
  endtask

  // Reset also clears the lock bits, so the model starts over
  task automatic do_reset;
    reset = 1'b1;
    {m_up, m_lo, m_cr, m_cfg, m_tmp} = '0;
    {m_ac, m_aw, m_bw} = 3'h0;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
  endtask

  // Model applies the old lock state, as the write edge sees it
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    logic lk;
    @(negedge clk_sys);
    reg_ptr = p;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    lk = m_cfg[6] | m_cfg[7];
    if (ce) case (p)
      TAEV_PTR_HIGH: if (!m_cfg[6]) m_up = d & TAEV_LIMIT_MASK;
      TAEV_PTR_LOW: if (!m_cfg[6]) m_lo = d & TAEV_LIMIT_MASK;
      TAEV_PTR_CRIT: if (!m_cfg[7]) m_cr = d & TAEV_LIMIT_MASK;
      TAEV_PTR_CONFIG: begin
        if (!lk) {m_cfg[10:9], m_cfg[3], m_cfg[1:0]} =
          {d[10:9], d[3], d[1:0]};
        if (!m_cfg[6]) m_cfg[2] = d[2];
        m_cfg[8] = d[8];
        m_cfg[7:6] = m_cfg[7:6] | d[7:6];
      end
      default: ;
    endcase
  endtask

  // Conversion; flags keep state between thresholds for hysteresis
  task automatic conv(input logic [15:0] t);
    logic signed [13:0] x, u, l, c, h;
    @(negedge clk_sys);
    conv_valid = 1'b1;
    conv_temp = t;
    @(negedge clk_sys);
    conv_valid = 1'b0;
    x = {t[12], t[12:1], 1'b0};
    u = {m_up[12], m_up[12:0]};
    l = {m_lo[12], m_lo[12:0]};
    c = {m_cr[12], m_cr[12:0]};
    h = hys(m_cfg[10:9]);
    if (!m_cfg[8]) begin
      m_tmp = t & TAEV_TEMP_MASK;
      m_ac = x >= c;
      if (x > u) m_aw = 1'b1;
      else if (x <= u - h) m_aw = 1'b0;
      if (x <= l - h) m_bw = 1'b1;
      else if (x >= l) m_bw = 1'b0;
    end
  endtask

  // Comparator-mode event level expected from the live flags
  function automatic logic act();
    logic cond;
    cond = m_cfg[2] ? m_ac : (m_ac | m_aw | m_bw);
    return m_cfg[3] & ~m_cfg[8] & cond;
  endfunction

  task automatic chk_all(input logic a);
    rd(TAEV_PTR_TEMP, {m_ac, m_aw, m_bw, m_tmp[12:0]}, "temp");
    rd(TAEV_PTR_CONFIG, {5'h00, m_cfg[10:6], 1'b0, a, m_cfg[3:0]},
      "config");
    rd(TAEV_PTR_HIGH, m_up, "high");
    rd(TAEV_PTR_LOW, m_lo, "low");
    rd(TAEV_PTR_CRIT, m_cr, "crit");
    chk("pin", {15'h0, a ^ ~m_cfg[1]}, {15'h0, event_pin_o});
    chk("oe", {15'h0, m_cfg[3]}, {15'h0, event_pin_oe});
    chk("line", {15'h0, m_cfg[3] ? a ^ ~m_cfg[1] : 1'b1},
      {15'h0, line});
    chk("shdn", {15'h0, m_cfg[8]}, {15'h0, shutdown});
  endtask

  // Main sequence: interrupt latch first, while its history is known
  initial begin
    void'($urandom(15));
    do_reset();
    chk_all(1'b0);
    wr(TAEV_PTR_HIGH, 16'h0190);
    wr(TAEV_PTR_LOW, 16'h0100);
    wr(TAEV_PTR_CRIT, 16'h0500);
    wr(TAEV_PTR_CONFIG, 16'h0209);
    conv(16'h0150);
    chk_all(1'b0);
    conv(16'h0200);
    chk_all(1'b1);
    conv(16'h0150);
    chk_all(1'b1);
    wr(TAEV_PTR_CONFIG, 16'h0229);
    chk_all(1'b0);
    conv(16'h07c0);
    chk_all(1'b1);
    wr(TAEV_PTR_CONFIG, 16'h0229);
    chk_all(1'b0);
    // Random comparator traffic; reserved limit bits always written
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        wr(TAEV_PTR_CONFIG, 16'h0200);
        wr(TAEV_PTR_HIGH, 16'($urandom_range(256, 768)) | 16'he003);
        wr(TAEV_PTR_LOW, 16'($urandom_range(128, 512)) | 16'he003);
        wr(TAEV_PTR_CRIT, 16'($urandom_range(512, 1536)) | 16'he003);
      end
      // Hysteresis selection drawn too, so every step size is exercised
      if (i % 4 == 0) wr(TAEV_PTR_CONFIG, 16'($urandom) & 16'h063e);
      conv(16'($urandom_range(64, 1664)));
      chk_all(act());
    end
    wr(TAEV_PTR_CONFIG, 16'h0208);
    conv(16'h1e64);
    chk_all(act());
    // Shutdown drops the event and ignores conversions
    wr(TAEV_PTR_CONFIG, 16'h0308);
    conv(16'h07c0);
    chk_all(act());
    wr(TAEV_PTR_CONFIG, 16'h0208);
    chk_all(act());
    // A write with the clock enable low must not land
    @(negedge clk_sys);
    ce = 1'b0;
    wr(TAEV_PTR_HIGH, 16'h0aa8);
    ce = 1'b1;
    chk_all(act());
    // Locks freeze fields and cannot be undone by writing zero
    wr(TAEV_PTR_CONFIG, 16'h0248);
    wr(TAEV_PTR_CONFIG, 16'h0007);
    wr(TAEV_PTR_HIGH, 16'h0400);
    wr(TAEV_PTR_CRIT, 16'h0300);
    chk_all(act());
    wr(TAEV_PTR_CONFIG, 16'h0080);
    wr(TAEV_PTR_CRIT, 16'h0100);
    wr(TAEV_PTR_CONFIG, 16'h0000);
    conv(16'h0320);
    chk_all(act());
    @(negedge clk_sys);
    do_reset();
    chk_all(1'b0);
    final_report();
  end
endmodule // thermal_alarm_event_logic_test
